// >>> lsf_status.v
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "lsf_defines.vh"
// ****************************************************************
// LIN status flag register bank
// ****************************************************************
module lsf_status #(
    parameter integer IDLE_CYCLES = `LSF_IDLE_CYCLES
) (
    input wire clk_i,
    input wire rst_i,
    // Register port
    input wire [3:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // Protocol engine events
    input wire slave_mode_i,
    input wire bus_active_i,
    input wire bus_asleep_i,
    input wire break_i,
    input wire xfer_start_i,
    input wire xfer_done_i,
    input wire id_rcvd_i,
    input wire id_clear_i,
    input wire int_event_i,
    input wire err_event_i,
    input wire [4:0] err_detail_i,
    input wire wake_tx_i,
    input wire wake_rx_i,
    input wire wake_clear_i,
    // Outputs
    output wire [7:0] lin_status_o,
    output reg stop_req_o,
    output wire irq_o
);
    reg idle_r, abort_r, data_request_flag_r, int_r, err_r, wake_r, done_r;
    reg busy_r;
    reg [4:0] errdet_r;
    wire idle_exp;
    wire ctrl_wr;
    wire clr_int;
    wire clr_err;
    wire stop_wr;
    wire [3:0] irq_stat;
    wire [3:0] irq_mask;

    assign ctrl_wr = wr_i && (addr_i == `LSF_ADDR_CTRL);
    assign clr_int = ctrl_wr && wdata_i[`LSF_C_CLRINT];
    assign clr_err = ctrl_wr && wdata_i[`LSF_C_CLRERR];
    assign stop_wr = ctrl_wr && wdata_i[`LSF_C_STOP];

    // Idle timer runs only in slave mode while awake
    lsf_idle_timer #(.IDLE_CYCLES(IDLE_CYCLES)) u_idle (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(bus_active_i),
        .enable_i(slave_mode_i && !bus_asleep_i),
        .expired_o(idle_exp)
    );

    // ************************************************************
    // Flags
    // ************************************************************
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            idle_r <= 1'b0;
            abort_r <= 1'b0;
            data_request_flag_r <= 1'b0;
            int_r <= 1'b0;
            err_r <= 1'b0;
            wake_r <= 1'b0;
            done_r <= 1'b0;
            busy_r <= 1'b0;
            errdet_r <= 5'h00;
            stop_req_o <= 1'b0;
        end else begin
            idle_r <= slave_mode_i && idle_exp && !bus_asleep_i;
            stop_req_o <= slave_mode_i && stop_wr;
            // Abort: early break or stop in slave mode, clean break clears
            if (slave_mode_i && ((break_i && busy_r) || stop_wr)) begin
                abort_r <= 1'b1;
            end else if (break_i && !busy_r) begin
                abort_r <= 1'b0;
            end
            // Identifier received flag
            if (!slave_mode_i) begin
                data_request_flag_r <= 1'b0;
            end else if (id_rcvd_i) begin
                data_request_flag_r <= 1'b1;
            end else if (id_clear_i) begin
                data_request_flag_r <= 1'b0;
            end
            // Set wins over clear for pending and error
            int_r <= int_event_i | (int_r & ~clr_int);
            err_r <= err_event_i | (err_r & ~clr_err);
            errdet_r <= err_detail_i | (errdet_r & {5{~clr_err}});
            // Wakeup: held after receive until cleared
            if (wake_rx_i) begin
                wake_r <= 1'b1;
            end else if (wake_clear_i) begin
                wake_r <= 1'b0;
            end
            // Transfer tracking and completion
            if (xfer_start_i) begin
                done_r <= 1'b0;
                busy_r <= 1'b1;
            end else if (xfer_done_i) begin
                done_r <= 1'b1;
                busy_r <= 1'b0;
            end
        end
    end

    // Status image, all read-only
    assign lin_status_o = {bus_active_i, idle_r, abort_r, data_request_flag_r,
                           int_r, err_r, wake_r | wake_tx_i, done_r};

    // Interrupt events: done, error, idle, early break (break while busy; stop does not raise it)
    lsf_irq #(.W(4)) u_irq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .event_i({xfer_done_i, err_event_i, idle_exp & ~idle_r, break_i & busy_r}),
        .clear_i((wr_i && addr_i == `LSF_ADDR_IRQ_STAT) ? wdata_i[3:0] : 4'h0),
        .mask_we_i(wr_i && addr_i == `LSF_ADDR_IRQ_MASK),
        .mask_i(wdata_i[3:0]),
        .stat_o(irq_stat),
        .mask_o(irq_mask),
        .irq_o(irq_o)
    );

    // Read data one cycle later; reads change nothing
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `LSF_ADDR_STATUS: rdata_o <= lin_status_o;
                `LSF_ADDR_ERRDET: rdata_o <= {3'h0, errdet_r};
                `LSF_ADDR_CTRL: rdata_o <= 8'h00;
                `LSF_ADDR_IRQ_STAT: rdata_o <= {4'h0, irq_stat};
                `LSF_ADDR_IRQ_MASK: rdata_o <= {4'h0, irq_mask};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule // lsf_status
`default_nettype wire

// >>> lsf_defines.vh
`ifndef LSF_DEFINES_VH
`define LSF_DEFINES_VH
// ****************************************************************
// Register map
// ****************************************************************
`define LSF_ADDR_W 4
`define LSF_ADDR_CTRL 4'h8
`define LSF_ADDR_STATUS 4'h9
`define LSF_ADDR_ERRDET 4'ha
`define LSF_ADDR_IRQ_STAT 4'h1
`define LSF_ADDR_IRQ_MASK 4'h2
`define LSF_STATUS_RESET 8'h00
// Status bit positions
`define LSF_B_ACTIVE 7
`define LSF_B_IDLE 6
`define LSF_B_ABORT 5
`define LSF_B_DATA_REQUEST_FLAG 4
`define LSF_B_INT 3
`define LSF_B_ERR 2
`define LSF_B_WAKE 1
`define LSF_B_DONE 0
// Control bit positions
`define LSF_C_STOP 7
`define LSF_C_CLRINT 3
`define LSF_C_CLRERR 2
// Idle timeout: 4 s at 50 MHz
`define LSF_IDLE_TIME_S 4
`define LSF_CLK_HZ 50000000
`define LSF_IDLE_CYCLES (`LSF_IDLE_TIME_S * `LSF_CLK_HZ)
`endif

// >>> lsf_idle_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "lsf_defines.vh"
// ****************************************************************
// Bus idle timer
// ****************************************************************
module lsf_idle_timer #(
    parameter integer IDLE_CYCLES = `LSF_IDLE_CYCLES
) (
    input wire clk_i,
    input wire rst_i,
    input wire restart_i,
    input wire enable_i,
    output reg expired_o
);
    reg [31:0] cnt_r;
    // Count idle cycles, restart on any activity
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 32'h0;
            expired_o <= 1'b0;
        end else if (restart_i || !enable_i) begin
            cnt_r <= 32'h0;
            expired_o <= 1'b0;
        end else if (cnt_r >= IDLE_CYCLES - 1) begin
            expired_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
    end
endmodule // lsf_idle_timer
`default_nettype wire

// >>> lsf_irq.v
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Sticky interrupt status with mask
// ****************************************************************
module lsf_irq #(
    parameter integer W = 4
) (
    input wire clk_i,
    input wire rst_i,
    input wire [W-1:0] event_i,
    input wire [W-1:0] clear_i,
    input wire mask_we_i,
    input wire [W-1:0] mask_i,
    output reg [W-1:0] stat_o,
    output reg [W-1:0] mask_o,
    output wire irq_o
);
    // Set wins over a clear in the same cycle
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_o <= {W{1'b0}};
            mask_o <= {W{1'b0}};
        end else begin
            stat_o <= (stat_o & ~clear_i) | event_i;
            if (mask_we_i) begin
                mask_o <= mask_i;
            end
        end
    end
    assign irq_o = |(stat_o & mask_o);
endmodule // lsf_irq
`default_nettype wire

// >>> lsf_status_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Status flag checker
// ********
module lsf_status_chk #(parameter integer IDLE_CYCLES = 20) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic slave_mode_i,
    input wire logic bus_active_i,
    input wire logic xfer_start_i,
    input wire logic xfer_done_i,
    input wire logic int_event_i,
    input wire logic err_event_i,
    input wire logic wake_tx_i,
    input wire logic [7:0] lin_status_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Write to the control register
    sequence s_ctl_wr;
        wr_i && addr_i == 4'h8;
    endsequence
    a_active_level: assert property (lin_status_o[7] == bus_active_i) else $error("active bit");
    a_idle_slave: assert property ($rose(lin_status_o[6]) |-> $past(slave_mode_i))
        else $error("idle flag outside slave mode");
    a_stop_abort: assert property (s_ctl_wr ##0 (wdata_i[7] && slave_mode_i) |=> lin_status_o[5])
        else $error("stop did not abort");
    a_data_request_flag_master: assert property (!slave_mode_i [*2] |-> !lin_status_o[4])
        else $error("data request in master mode");
    a_int_set: assert property (int_event_i |=> lin_status_o[3]) else $error("int flag");
    a_int_sticky: assert property (lin_status_o[3] && !(wr_i && addr_i == 4'h8 && wdata_i[3])
        |=> lin_status_o[3]) else $error("int flag lost");
    a_int_clear: assert property (s_ctl_wr ##0 (wdata_i[3] && !int_event_i) |=> !lin_status_o[3])
        else $error("int flag not cleared");
    a_err_clear: assert property (s_ctl_wr ##0 (wdata_i[2] && !err_event_i) |=> !lin_status_o[2])
        else $error("error flag not cleared");
    a_wake_tx: assert property (wake_tx_i |-> lin_status_o[1]) else $error("wake bit");
    a_done_set: assert property (xfer_done_i |=> lin_status_o[0]) else $error("done bit");
    a_done_start: assert property (xfer_start_i && !xfer_done_i |=> !lin_status_o[0])
        else $error("done not cleared");
    a_read_data: assert property (rd_i && addr_i == 4'h9 |=> rdata_o == $past(lin_status_o))
        else $error("status read");
endmodule // lsf_status_chk
bind lsf_status lsf_status_chk #(.IDLE_CYCLES(IDLE_CYCLES)) lsf_status_chk_inst (.clk_i, .rst_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .slave_mode_i, .bus_active_i, .xfer_start_i,
    .xfer_done_i, .int_event_i, .err_event_i, .wake_tx_i, .lin_status_o);
`default_nettype wire

// >>> lsf_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Protocol engine model
// ********
module lsf_engine_model (
    input wire logic clk_i,
    output logic [17:0] ev_o
);
    // Bits: 0 slave, 1 active, 2 asleep, 3 break, 4 start, 5 done, 6 id, 7 id clear,
    // 8 int, 9 err, 10 wake tx, 11 wake rx, 12 wake clear, 17:13 error detail
    initial ev_o = 18'h00000;
    // One-cycle event pulse
    task pulse(input logic [17:0] m);
        @(posedge clk_i) ev_o <= ev_o | m;
        @(posedge clk_i) ev_o <= ev_o & ~m;
        #1;
    endtask
    // Level change, settled one edge later
    task level(input int b, input logic v);
        @(posedge clk_i) ev_o[b] <= v;
        @(posedge clk_i) #1;
    endtask
endmodule // lsf_engine_model
`default_nettype wire

// >>> lsf_status_test.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Status flag bench
// ********
module lsf_status_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o, st, d;
    logic stop_req_o, irq_o, irq_a;
    logic [17:0] ev;
    int num_errors = 0;
    int samples_checked = 0;
    // Clock
    always #10 clk_i = ~clk_i;
    lsf_engine_model lsf_engine_model_inst (.clk_i(clk_i), .ev_o(ev));
    lsf_status #(.IDLE_CYCLES(20)) lsf_status_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .slave_mode_i(ev[0]),
        .bus_active_i(ev[1]), .bus_asleep_i(ev[2]), .break_i(ev[3]), .xfer_start_i(ev[4]),
        .xfer_done_i(ev[5]), .id_rcvd_i(ev[6]), .id_clear_i(ev[7]), .int_event_i(ev[8]),
        .err_event_i(ev[9]), .err_detail_i(ev[17:13]), .wake_tx_i(ev[10]), .wake_rx_i(ev[11]),
        .wake_clear_i(ev[12]), .lin_status_o(st), .stop_req_o(stop_req_o), .irq_o(irq_o));
    task tally_and_finish;
        if (num_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, v};
        @(posedge clk_i) wr_i <= 1'b0;
        #1;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_i) {rd_i, addr_i} <= {1'b1, a};
        @(posedge clk_i) rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    // Pulse one engine event, then compare the masked status image
    task pc(input int b, input logic [7:0] m, input logic [7:0] e);
        lsf_engine_model_inst.pulse(18'd1 << b);
        chk(st & m, e);
    endtask
    // Hang guard
    initial begin
        repeat (3000) @(posedge clk_i);
        num_errors++;
        tally_and_finish;
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h9, d);
        chk(d, 8'h00);
        lsf_engine_model_inst.level(0, 1'b1);
        pc(5, 8'h01, 8'h01);
        pc(4, 8'h01, 8'h00);
        pc(3, 8'h20, 8'h20);
        pc(5, 8'h01, 8'h01);
        pc(3, 8'h20, 8'h00);
        wr(4'h8, 8'h80);
        chk(st & 8'h20, 8'h20);
        chk({7'h00, stop_req_o}, 8'h01);
        pc(6, 8'h10, 8'h10);
        lsf_engine_model_inst.level(0, 1'b0);
        chk(st & 8'h10, 8'h00);
        lsf_engine_model_inst.level(0, 1'b1);
        pc(8, 8'h08, 8'h08);
        rd(4'h9, d);
        chk(d & 8'h08, 8'h08);
        wr(4'h8, 8'h00);
        chk(st & 8'h08, 8'h08);
        wr(4'h8, 8'h08);
        chk(st & 8'h08, 8'h00);
        rd(4'h8, d);
        chk(d, 8'h00);
        lsf_engine_model_inst.pulse(18'h02200);
        chk(st & 8'h04, 8'h04);
        rd(4'ha, d);
        chk(d, 8'h01);
        wr(4'h8, 8'h04);
        chk(st & 8'h04, 8'h00);
        rd(4'ha, d);
        chk(d, 8'h00);
        lsf_engine_model_inst.level(10, 1'b1);
        chk(st & 8'h02, 8'h02);
        lsf_engine_model_inst.level(10, 1'b0);
        chk(st & 8'h02, 8'h00);
        pc(11, 8'h02, 8'h02);
        lsf_engine_model_inst.level(1, 1'b1);
        chk(st & 8'h80, 8'h80);
        lsf_engine_model_inst.level(1, 1'b0);
        chk(st & 8'h80, 8'h00);
        repeat (25) @(posedge clk_i);
        #1 chk(st & 8'h40, 8'h40);
        // Bus asleep: idle flag must drop, timer stays off
        lsf_engine_model_inst.level(2, 1'b1);
        chk(st & 8'h40, 8'h00);
        // Interrupt: sticky status, mask, write-one clear
        wr(4'h2, 8'h00);
        wr(4'h1, 8'hff);
        pc(5, 8'h01, 8'h01);
        rd(4'h1, d);
        chk(d & 8'h08, 8'h08);
        irq_a = irq_o;
        wr(4'h2, 8'h0f);
        chk({7'h00, irq_a ^ irq_o}, 8'h01);
        wr(4'h1, 8'hff);
        chk({7'h00, irq_o}, 8'h00);
        rd(4'hf, d);
        chk(d, 8'h00);
        tally_and_finish;
    end
endmodule // lsf_status_test
`default_nettype wire
